// *** pfsel_consts.svh ***
`ifndef PFSEL_CONSTS_SVH
`define PFSEL_CONSTS_SVH

// Register offsets
`define PFSEL_OFF_B_LO 4'h0
`define PFSEL_OFF_B_HI 4'h1
`define PFSEL_OFF_C_LO 4'h2
`define PFSEL_OFF_C_HI 4'h3
`define PFSEL_OFF_D_LO 4'h4
`define PFSEL_OFF_D_HI 4'h5
`define PFSEL_OFF_E_LO 4'h6
`define PFSEL_OFF_E_HI 4'h7
`define PFSEL_OFF_F_LO 4'h8
`define PFSEL_OFF_F_HI 4'h9
`define PFSEL_NUM_REGS 10

// Reset values and writable bits
`define PFSEL_SEL_RESET 8'h00
`define PFSEL_MASK_FULL 8'hFF
`define PFSEL_MASK_D_HI 8'h3F
`define PFSEL_RD_UNMAPPED 8'h00

// Field layout
`define PFSEL_FIELD_W 2
`define PFSEL_NUM_PINS 40
`define PFSEL_NUM_SEGS 46
`define PFSEL_NUM_ADC 12

// Marker for a pin with no segment or analog channel
`define PFSEL_SEG_NONE 6'h3F
`define PFSEL_ADC_NONE 4'hF

`endif

// *** pfsel_pkg.sv ***
package pfsel_pkg;

  typedef enum logic [3:0] {
    FN_GPIO,
    FN_TMR_OUT,
    FN_ANALOG,
    FN_VREF,
    FN_CMP_OUT,
    FN_CMP_IN,
    FN_UART,
    FN_SERIAL,
    FN_OSC,
    FN_LCD_SEG,
    FN_LCD_PWR,
    FN_SUPPLY
  } pfsel_func_e;

  typedef struct packed {
    pfsel_func_e func;
    logic [1:0] code;
  } pfsel_pin_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfsel_req_s;

endpackage

// *** pfsel_top.sv ***
`timescale 1ns/10ps
`include "pfsel_consts.svh"

// Functional notes
// - B3/B2 codes: I/O, timer out, segment.
// - B1 I/O for three codes; B0 comparator.
// - B7/B6 oscillator pins, timer-1 capture/output.
// - B5 reset-shared I/O; B4 comparator-1 out.
// - C3/C2 timer, analog 3/2, segments.
// - C1 reference, comparator; C0 external reference.
// - C7/C6 interrupt, timer-6/0, analog 7/6.
// - C5/C4 timer-5/1, analog 5/4, segments.
// - D3/D2 timer-7/2, analog 11/10, UART1.
// - D1/D0 UART1, analog 9/8, segments.
// - D6/D5 timer-2, comparator-1, UART0 transmit.
// - D4 timer-3, UART0, comparator-1 negative.
// - Port D high bits 7:6 read zero.
// - E3/E2 timer-1, second SPI clock/data.
// - E1/E0 timer-0, second SPI out/select.
// - E7/E6 LCD bias and pump pins.
// - E5 pump pin; E4 port supply.
// - F3/F2 serial clock and data.
// - F1/F0 timer-6/7 outputs, SPI pins.
// - F7/F6 UART1, comparator-0 inputs, segment.
// - F5/F4 timer-0, low-speed crystal pins.
module pfsel_top (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire pfsel_pkg::pfsel_req_s req_i,
  output logic [7:0] rdata_o,
  output pfsel_pkg::pfsel_pin_s [`PFSEL_NUM_PINS-1:0] pin_cfg_o,
  output logic [`PFSEL_NUM_PINS-1:0] pin_gpio_o,
  output logic [`PFSEL_NUM_SEGS-1:0] lcd_seg_en_o,
  output logic [`PFSEL_NUM_ADC-1:0] adc_ch_en_o
);

  logic [7:0] sel_r [`PFSEL_NUM_REGS];
  logic [7:0] rdata_r;
  logic [8*`PFSEL_NUM_REGS-1:0] sel_flat;
  pfsel_pkg::pfsel_pin_s [`PFSEL_NUM_PINS-1:0] pin_cfg_r;
  pfsel_pkg::pfsel_pin_s [`PFSEL_NUM_PINS-1:0] pin_cfg_nxt;
  logic [`PFSEL_NUM_PINS-1:0] pin_gpio_r;
  logic [`PFSEL_NUM_PINS-1:0] pin_gpio_nxt;
  logic [`PFSEL_NUM_SEGS-1:0] lcd_seg_en_r;
  logic [`PFSEL_NUM_SEGS-1:0] lcd_seg_en_nxt;
  logic [`PFSEL_NUM_ADC-1:0] adc_ch_en_r;
  logic [`PFSEL_NUM_ADC-1:0] adc_ch_en_nxt;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a < 4'(`PFSEL_NUM_REGS));
  endfunction

  function automatic logic [7:0] wr_mask(input logic [3:0] a);
    // Port D high register keeps only six bits
    // upper bits dropped
    wr_mask = (a == `PFSEL_OFF_D_HI) ? `PFSEL_MASK_D_HI : `PFSEL_MASK_FULL;
  endfunction

  // Function class per code, packed as code3,code2,code1,code0
  function automatic pfsel_pkg::pfsel_func_e pin_class(
    input logic [5:0] pin,
    input logic [1:0] code
  );
    logic [15:0] t;
    t = {4{pfsel_pkg::FN_GPIO}};
    case (pin)
      // port B bit 0 and 1
      6'h00: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_CMP_OUT,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h01: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_GPIO,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port B bit 2 and 3
      6'h02: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_TMR_OUT,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h03: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_TMR_OUT,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port B bit 4 and 5
      6'h04: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_CMP_OUT,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h05: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_GPIO,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port B bit 6 and 7
      6'h06: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_OSC,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      6'h07: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_OSC,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port C bit 0 and 1
      6'h08: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_VREF, pfsel_pkg::FN_GPIO};
      6'h09: t = {pfsel_pkg::FN_CMP_OUT, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_VREF, pfsel_pkg::FN_GPIO};
      // port C bit 2 and 3
      6'h0A: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_TMR_OUT,
                  pfsel_pkg::FN_ANALOG, pfsel_pkg::FN_GPIO};
      6'h0B: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port C bit 4 and 5
      6'h0C: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_TMR_OUT,
                  pfsel_pkg::FN_ANALOG, pfsel_pkg::FN_GPIO};
      6'h0D: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port C bit 6 and 7
      6'h0E: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_TMR_OUT,
                  pfsel_pkg::FN_ANALOG, pfsel_pkg::FN_GPIO};
      6'h0F: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port D bit 0 and 1
      6'h10: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      6'h11: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_UART, pfsel_pkg::FN_GPIO};
      // port D bit 2, 3 and 4
      6'h12: t = {pfsel_pkg::FN_ANALOG, pfsel_pkg::FN_UART,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      6'h13: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_ANALOG,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      6'h14: t = {pfsel_pkg::FN_CMP_IN, pfsel_pkg::FN_UART,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port D bit 5 and 6
      6'h15: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_CMP_IN,
                  pfsel_pkg::FN_UART, pfsel_pkg::FN_GPIO};
      6'h16: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_CMP_OUT,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port E bit 0 and 1
      6'h18: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h19: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port E bit 2 and 3
      6'h1A: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h1B: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port E bit 4 and 5
      6'h1C: t = {pfsel_pkg::FN_SUPPLY, pfsel_pkg::FN_GPIO,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h1D: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_LCD_PWR,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port E bit 6 and 7
      6'h1E: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_LCD_PWR,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h1F: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_LCD_PWR,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port F bit 0 and 1
      6'h20: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      6'h21: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      // port F bit 2 and 3
      6'h22: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h23: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_SERIAL,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port F bit 4 and 5
      6'h24: t = {pfsel_pkg::FN_OSC, pfsel_pkg::FN_GPIO,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      6'h25: t = {pfsel_pkg::FN_OSC, pfsel_pkg::FN_TMR_OUT,
                  pfsel_pkg::FN_GPIO, pfsel_pkg::FN_GPIO};
      // port F bit 6 and 7
      6'h26: t = {pfsel_pkg::FN_LCD_SEG, pfsel_pkg::FN_CMP_IN,
                  pfsel_pkg::FN_UART, pfsel_pkg::FN_GPIO};
      6'h27: t = {pfsel_pkg::FN_CMP_IN, pfsel_pkg::FN_UART,
                  pfsel_pkg::FN_TMR_OUT, pfsel_pkg::FN_GPIO};
      default: t = {4{pfsel_pkg::FN_GPIO}};
    endcase
    pin_class = pfsel_pkg::pfsel_func_e'(t[{code, 2'b00} +: 4]);
  endfunction

  // Segment number a pin drives when its code selects a segment
  function automatic logic [5:0] pin_seg(input logic [5:0] pin);
    case (pin)
      6'h00: pin_seg = 6'h1A;
      6'h01: pin_seg = 6'h19;
      6'h02: pin_seg = 6'h0E;
      6'h03: pin_seg = 6'h15;
      6'h04: pin_seg = 6'h16;
      6'h05: pin_seg = 6'h1E;
      6'h06: pin_seg = 6'h1D;
      6'h07: pin_seg = 6'h1C;
      6'h08: pin_seg = 6'h2A;
      6'h0A: pin_seg = 6'h29;
      6'h0B: pin_seg = 6'h28;
      6'h0C: pin_seg = 6'h27;
      6'h0D: pin_seg = 6'h26;
      6'h0E: pin_seg = 6'h25;
      6'h0F: pin_seg = 6'h24;
      6'h10: pin_seg = 6'h23;
      6'h11: pin_seg = 6'h22;
      6'h13: pin_seg = 6'h21;
      6'h15: pin_seg = 6'h20;
      6'h16: pin_seg = 6'h1B;
      6'h18: pin_seg = 6'h07;
      6'h19: pin_seg = 6'h06;
      6'h1A: pin_seg = 6'h05;
      6'h1B: pin_seg = 6'h04;
      6'h1D: pin_seg = 6'h2D;
      6'h1E: pin_seg = 6'h2C;
      6'h1F: pin_seg = 6'h2B;
      6'h20: pin_seg = 6'h0D;
      6'h21: pin_seg = 6'h0C;
      6'h22: pin_seg = 6'h0B;
      6'h23: pin_seg = 6'h0A;
      6'h26: pin_seg = 6'h1F;
      default: pin_seg = `PFSEL_SEG_NONE;
    endcase
  endfunction

  // Analog channel a pin carries when its code selects analog
  function automatic logic [3:0] pin_adc(input logic [5:0] pin);
    case (pin)
      6'h08: pin_adc = 4'h0;
      6'h09: pin_adc = 4'h1;
      6'h0A: pin_adc = 4'h2;
      6'h0B: pin_adc = 4'h3;
      6'h0C: pin_adc = 4'h4;
      6'h0D: pin_adc = 4'h5;
      6'h0E: pin_adc = 4'h6;
      6'h0F: pin_adc = 4'h7;
      6'h10: pin_adc = 4'h8;
      6'h11: pin_adc = 4'h9;
      6'h12: pin_adc = 4'hA;
      6'h13: pin_adc = 4'hB;
      default: pin_adc = `PFSEL_ADC_NONE;
    endcase
  endfunction

  // Selector registers
  // cleared at reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `PFSEL_NUM_REGS; i++) begin
        sel_r[i] <= `PFSEL_SEL_RESET;
      end
    end else if (req_i.wr && mapped(req_i.addr)) begin
      sel_r[req_i.addr] <= req_i.wdata & wr_mask(req_i.addr);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= `PFSEL_RD_UNMAPPED;
    end else if (req_i.rd && mapped(req_i.addr)) begin
      rdata_r <= sel_r[req_i.addr];
    end else begin
      rdata_r <= `PFSEL_RD_UNMAPPED;
    end
  end

  always_comb begin
    for (int i = 0; i < `PFSEL_NUM_REGS; i++) begin
      sel_flat[8*i +: 8] = sel_r[i];
    end
  end

  // Pin decode
  // each pin but D7 decodes its code by its own table; D7 takes the all-I/O default
  always_comb begin
    logic [5:0] s;
    logic [3:0] a;
    s = '0;
    a = '0;
    lcd_seg_en_nxt = '0;
    adc_ch_en_nxt = '0;
    for (int p = 0; p < `PFSEL_NUM_PINS; p++) begin
      pin_cfg_nxt[p].code = sel_flat[2*p +: 2];
      pin_cfg_nxt[p].func = pin_class(6'(p), sel_flat[2*p +: 2]);
      pin_gpio_nxt[p] = (pin_cfg_nxt[p].func == pfsel_pkg::FN_GPIO);
      s = pin_seg(6'(p));
      a = pin_adc(6'(p));
      if (pin_cfg_nxt[p].func == pfsel_pkg::FN_LCD_SEG &&
          s != `PFSEL_SEG_NONE) begin
        lcd_seg_en_nxt[s] = 1'b1;
      end
      if (pin_cfg_nxt[p].func == pfsel_pkg::FN_ANALOG &&
          a != `PFSEL_ADC_NONE) begin
        adc_ch_en_nxt[a] = 1'b1;
      end
    end
  end

  // Registered decode outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_cfg_r <= '0;
      pin_gpio_r <= '1;
      lcd_seg_en_r <= '0;
      adc_ch_en_r <= '0;
    end else begin
      pin_cfg_r <= pin_cfg_nxt;
      pin_gpio_r <= pin_gpio_nxt;
      lcd_seg_en_r <= lcd_seg_en_nxt;
      adc_ch_en_r <= adc_ch_en_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign pin_cfg_o = pin_cfg_r;
  assign pin_gpio_o = pin_gpio_r;
  assign lcd_seg_en_o = lcd_seg_en_r;
  assign adc_ch_en_o = adc_ch_en_r;

  a_pdhi_upper_zero: assert property (
    req_i.rd && req_i.addr == `PFSEL_OFF_D_HI |=> rdata_o[7:6] == 2'b00
  ) else $error("Port D high upper bits read nonzero");

  a_write_read_back: assert property (
    req_i.wr && req_i.addr == `PFSEL_OFF_B_LO
    ##1 req_i.rd && req_i.addr == `PFSEL_OFF_B_LO && !req_i.wr
    |=> rdata_o == $past(req_i.wdata, 2)
  ) else $error("Selector write not read back");

  a_b3_timer_out: assert property (
    sel_r[0][7:6] == 2'b10 |=> pin_cfg_o[3].func == pfsel_pkg::FN_TMR_OUT
  ) else $error("B3 code 10 not timer output");

  a_b3_segment: assert property (
    sel_r[0][7:6] == 2'b11 |=> lcd_seg_en_o[21] && !pin_gpio_o[3]
  ) else $error("B3 code 11 not segment 21");

  a_b1_stays_io: assert property (
    sel_r[0][3:2] != 2'b11 |=> pin_gpio_o[1]
  ) else $error("B1 lost I/O function");

  a_b6_timer_out: assert property (
    sel_r[1][5:4] == 2'b01 |=> pin_cfg_o[6].func == pfsel_pkg::FN_TMR_OUT
  ) else $error("B6 code 01 not timer output");

  a_c2_analog: assert property (
    sel_r[2][5:4] == 2'b01 |=> adc_ch_en_o[2] && !pin_gpio_o[10]
  ) else $error("C2 code 01 not analog 2");

  a_d2_analog: assert property (
    sel_r[4][5:4] == 2'b11 |=> adc_ch_en_o[10]
  ) else $error("D2 code 11 not analog 10");

  a_e4_supply: assert property (
    sel_r[7][1:0] == 2'b11 |=> pin_cfg_o[28].func == pfsel_pkg::FN_SUPPLY
  ) else $error("E4 code 11 not supply input");

  a_f4_crystal: assert property (
    $changed(sel_r[9][1:0]) && sel_r[9][1:0] != 2'b11
    ##1 sel_r[9][1:0] != 2'b11 |-> pin_gpio_o[36] [*2]
  ) else $error("F4 not I/O outside code 11");

  a_d4_cmp_in: assert property (
    sel_r[5][1:0] == 2'b11 |=> pin_cfg_o[20].func == pfsel_pkg::FN_CMP_IN
  ) else $error("D4 code 11 not comparator input");

  a_e7_bias_pin: assert property (
    sel_r[7][7:6] == 2'b10 |=> pin_cfg_o[31].func == pfsel_pkg::FN_LCD_PWR
  ) else $error("E7 code 10 not LCD bias pin");

  a_c1_cmp_out: assert property (
    sel_r[2][3:2] == 2'b11 |=> pin_cfg_o[9].func == pfsel_pkg::FN_CMP_OUT
  ) else $error("C1 code 11 not comparator output");

  c_segment_used: cover property (lcd_seg_en_o[45]);
  c_pdhi_write: cover property (req_i.wr && req_i.addr == `PFSEL_OFF_D_HI);
  c_uart_pin: cover property (pin_cfg_o[38].func == pfsel_pkg::FN_UART);
  c_adc_used: cover property (adc_ch_en_o[11]);

endmodule

// *** pfsel_periph_model.sv ***
`timescale 1ns/10ps
module pfsel_periph_model (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [39:0] pin_gpio_i,
  input wire logic [39:0] periph_en_i,
  input wire logic [39:0] dir_in_i,
  output logic [7:0] fault_cnt_o
);
  logic [39:0] gpio_d_r;
  logic bad;
  assign bad = |((gpio_d_r ^ pin_gpio_i) & periph_en_i) |
               |(pin_gpio_i & periph_en_i & ~dir_in_i);
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gpio_d_r <= '1;
    end else begin
      gpio_d_r <= pin_gpio_i;
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_cnt_o <= 8'h00;
    end else if (bad) begin
      fault_cnt_o <= fault_cnt_o + 8'h01;
    end
  end
endmodule

// *** pin_function_select_bcdef_test.sv ***
`timescale 1ns/10ps
`include "pfsel_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module pin_function_select_bcdef_test;
  // Four function nibbles a pin, code 3 first; pins F7 down to B0
  localparam logic [639:0] FTAB = {
    128'h5610_9560_8100_8000_9700_9700_9710_9710,
    128'h9A00_9A00_9A00_B000_9710_9700_9710_9700,
    128'h0000_9410_9560_5610_9210_2610_9260_9210,
    128'h9210_9120_9210_9120_9210_9120_4230_9230,
    128'h9800_9810_9000_9400_9100_9100_9000_9400};
  localparam logic [45:0] SEG_ALL = 46'h3FFFFE607CF0;
  logic clock_i;
  logic resetn_i;
  pfsel_pkg::pfsel_req_s req;
  logic [7:0] rdata;
  pfsel_pkg::pfsel_pin_s [`PFSEL_NUM_PINS-1:0] cfg;
  logic [`PFSEL_NUM_PINS-1:0] gpio;
  logic [`PFSEL_NUM_SEGS-1:0] seg;
  logic [`PFSEL_NUM_ADC-1:0] adc;
  logic [39:0] pen;
  logic [39:0] pdir;
  logic [7:0] faults;
  logic [7:0] pats [6] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h1B, 8'hE4};
  logic [11:0] adc_exp [4] = '{12'h000, 12'h054, 12'hBAB, 12'h400};
  int errors;
  int n_compared;

  pfsel_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req),
    .rdata_o(rdata), .pin_cfg_o(cfg), .pin_gpio_o(gpio),
    .lcd_seg_en_o(seg), .adc_ch_en_o(adc));
  pfsel_periph_model u_periph (.clock_i(clock_i), .resetn_i(resetn_i),
    .pin_gpio_i(gpio), .periph_en_i(pen), .dir_in_i(pdir),
    .fault_cnt_o(faults));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    complete_run();
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  task automatic check_pins(input logic [7:0] p);
    logic [1:0] c;
    logic [3:0] f;
    for (int i = 0; i < 40; i++) begin
      c = (i == 23) ? 2'b00 : p[2*(i%4)+:2];
      f = FTAB[i*16+c*4+:4];
      `CHK("func", f, cfg[i].func)
      `CHK("code", c, cfg[i].code)
      `CHK("gpio", f == 4'h0, gpio[i])
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    req = '0;
    pen = '0;
    pdir = '0;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check_pins(8'h00);
    `CHK("seg", 46'h0, seg)
    `CHK("adc", 12'h0, adc)
    for (int r = 0; r < 10; r++) rd_chk(4'(r), 8'h00);
    $display("test reset_state done");

    for (int j = 0; j < 6; j++) begin
      for (int r = 0; r < 10; r++) wr(4'(r), pats[j]);
      @(posedge clock_i);
      #1;
      check_pins(pats[j]);
      if (j < 4) begin
        `CHK("seg", (j == 3) ? SEG_ALL : 46'h0, seg)
        `CHK("adc", adc_exp[j], adc)
      end
      for (int r = 0; r < 10; r++) begin
        rd_chk(4'(r), (r == 5) ? (pats[j] & `PFSEL_MASK_D_HI) : pats[j]);
      end
    end
    $display("test code_patterns done");

    wr(4'hA, 8'hFF);
    wr(4'hF, 8'h5A);
    rd_chk(4'hA, `PFSEL_RD_UNMAPPED);
    rd_chk(4'hF, `PFSEL_RD_UNMAPPED);
    rd_chk(4'h0, 8'hE4);
    rd_chk(4'h9, 8'hE4);
    $display("test unmapped done");

    wr(4'h1, 8'h34);
    @(posedge clock_i);
    req.addr <= 4'h0;
    req.wdata <= 8'h12;
    req.wr <= 1'b1;
    @(posedge clock_i);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge clock_i);
    req.addr <= 4'h1;
    #1;
    `CHK("rdata b2b0", 8'h12, rdata)
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1;
    `CHK("rdata b2b1", 8'h34, rdata)
    @(posedge clock_i);
    #1;
    `CHK("rdata idle", 8'h00, rdata)
    $display("test back_to_back done");

    wr(4'h0, 8'h00);
    @(posedge clock_i);
    pdir <= 40'h8;
    pen <= 40'h8;
    repeat (3) @(posedge clock_i);
    pen <= '0;
    @(posedge clock_i);
    wr(4'h0, 8'hC0);
    @(posedge clock_i);
    #1;
    `CHK("gpio b3", 1'b0, gpio[3])
    `CHK("lcd_segment_21", 1'b1, seg[21])
    `CHK("faults", 8'h00, faults)
    $display("test shared_input done");

    wr(4'h7, 8'hFF);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    #1;
    check_pins(8'h00);
    `CHK("seg", 46'h0, seg)
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd_chk(4'h7, 8'h00);
    rd_chk(4'h0, 8'h00);
    $display("test mid_reset done");
    complete_run();
  end
endmodule
